// ==== inc/mrx_pkg.sv ====
// Shared constants and carrier types for the receive frame writer.
// Assumes byte-wide GMII-style receive pins and a 32-bit client stream.
package mrx_pkg;

  // ==========================================================================
  // Link framing bytes
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;

  // ==========================================================================
  // Frame and payload length limits in bytes, the type threshold and the VLAN tag identifier
  localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
  localparam logic [15:0] VLAN_EXTRA = 16'h0004;
  localparam logic [15:0] STACK_EXTRA = 16'h0008;
  localparam logic [15:0] TRUNC_SLACK = 16'h000b;
  localparam logic [15:0] TYPE_MIN = 16'h0600;
  localparam logic [15:0] TPID_VLAN = 16'h8100;
  localparam logic [15:0] PAY_MIN_BASIC = 16'h002e;
  localparam logic [15:0] PAY_MIN_VLAN = 16'h002a;
  localparam logic [15:0] PAY_MIN_STACK = 16'h0026;
  localparam logic [15:0] PAY_LIMIT = 16'h0600;
  localparam logic [15:0] CRC_LEN = 16'h0004;

  // ==========================================================================
  // Header layout, byte positions after the start-of-frame delimiter
  localparam logic [15:0] HDR_BASIC = 16'h000e;
  localparam logic [15:0] HDR_VLAN = 16'h0012;
  localparam logic [15:0] HDR_STACK = 16'h0016;
  localparam logic [15:0] LT_POS = 16'h000c;
  localparam logic [15:0] INNER_POS = 16'h0010;
  localparam logic [15:0] CLT_STACK_POS = 16'h0014;

  // ==========================================================================
  // Word packing and error vector layout
  localparam logic [1:0] ALIGN_START_LANE = 2'h2;
  localparam logic [1:0] PLAIN_START_LANE = 2'h0;
  localparam logic [2:0] DELAY_FULL = 3'h4;
  localparam int ERR_LEN_STREAM = 0;
  localparam int ERR_LEN_FIFO = 1;
  localparam int ERR_PHY = 2;
  localparam int ERR_TRUNC = 3;
  localparam int THR_W = 8;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] data;
    logic sop;
    logic eop;
    logic [1:0] empty;
    logic [3:0] err;
  } mrx_word_s;

  typedef struct packed {
    logic [15:0] max_len;
    logic skip_payload_len_check;
    logic strip_crc_pad;
    logic rx_align_en;
  } mrx_cfg_s;

  typedef struct packed {
    logic [THR_W-1:0] almost_empty;
    logic [THR_W-1:0] almost_full;
    logic [THR_W-1:0] section_empty;
    logic [THR_W-1:0] section_full;
  } mrx_thr_s;

endpackage

// ==== rtl/mrx_rx_frame_writer.sv ====
// Receive frame qualification, length checking and word delivery.
// Assumes the PHY drives dv/er/rxd synchronous to gmii_rx_clk, which runs
// between frames, and that the client sits on ref_clk.
`timescale 1ns/1ps

module mrx_rx_frame_writer #(
  parameter bit FIFO_VARIANT = 1'b0,
  parameter int AW = 2
) (
  input wire logic ref_clk, // Client side clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic gmii_rx_clk, // Receive clock from the PHY
  input wire logic gmii_rx_dv, // Receive data valid
  input wire logic gmii_rx_er, // Receive symbol error
  input wire logic [7:0] gmii_rxd, // Receive data byte
  input wire mrx_pkg::mrx_cfg_s cfg, // Static receive configuration
  input wire mrx_pkg::mrx_thr_s thr, // Buffer thresholds in words
  input wire logic rx_ready, // Client ready
  output mrx_pkg::mrx_word_s rx_beat, // Client data beat
  output logic rx_valid, // Client beat valid
  output logic rx_a_empty, // Level at or below almost-empty
  output logic rx_a_full, // Free space at or below almost-full
  output logic rx_sect_empty, // Level at or above section-empty
  output logic rx_sect_full // Level at or above section-full
);

  localparam int DEPTH = 2 ** AW;
  localparam int LEN_BIT = FIFO_VARIANT ? mrx_pkg::ERR_LEN_FIFO : mrx_pkg::ERR_LEN_STREAM;

  typedef enum logic [1:0] {L_IDLE, L_RECV, L_DROP} mrx_lstate_e;
  typedef enum logic {S_PASS, S_DROP} mrx_sstate_e;

  function automatic logic [AW:0] gray_to_bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ==========================================================================
  // Link domain reset and configuration crossing
  logic lrst_s1_reg;
  logic lrst_reg;
  mrx_pkg::mrx_cfg_s cfg_s1_reg;
  mrx_pkg::mrx_cfg_s cfg_reg;

  always_ff @(posedge gmii_rx_clk or posedge rst) begin
    if (rst) begin
      lrst_s1_reg <= 1'b1;
      lrst_reg <= 1'b1;
    end else begin
      lrst_s1_reg <= 1'b0;
      lrst_reg <= lrst_s1_reg;
    end
  end

  // Configuration is quasi-static; two flops per bit are enough
  always_ff @(posedge gmii_rx_clk or posedge lrst_reg) begin
    if (lrst_reg) begin
      cfg_s1_reg <= '0;
      cfg_reg <= '0;
    end else begin
      cfg_s1_reg <= cfg;
      cfg_reg <= cfg_s1_reg;
    end
  end

  // ==========================================================================
  // Link domain pin capture and state
  logic dv_reg;
  logic er_reg;
  logic [7:0] rxd_reg;
  mrx_lstate_e lst_reg;
  logic [15:0] cnt_reg;
  logic [15:0] lt_reg;
  logic [15:0] in16_reg;
  logic [15:0] in20_reg;
  logic [31:0] dly_reg;
  logic [2:0] dly_n_reg;
  logic [31:0] part_reg;
  logic [1:0] lane_reg;
  logic part_v_reg;
  logic [31:0] pend_reg;
  logic pend_v_reg;
  logic sop_pend_reg;
  logic phy_err_reg;
  logic ovf_reg;
  logic [AW:0] wptr_reg;
  logic [AW:0] wgray_reg;
  logic [AW:0] rgray_s1_reg;
  logic [AW:0] rgray_s2_reg;
  logic [AW:0] rgray_reg;
  mrx_pkg::mrx_word_s mem [DEPTH];

  always_ff @(posedge gmii_rx_clk or posedge lrst_reg) begin
    if (lrst_reg) begin
      dv_reg <= 1'b0;
      er_reg <= 1'b0;
      rxd_reg <= 8'h00;
    end else begin
      dv_reg <= gmii_rx_dv;
      er_reg <= gmii_rx_er;
      rxd_reg <= gmii_rxd;
    end
  end

  // ==========================================================================
  // Frame classification and length checks
  logic is_vlan;
  logic is_stack;
  logic [15:0] clt;
  logic [15:0] hdr;
  logic [15:0] minp;
  logic [15:0] maxl;
  logic [15:0] pay;
  logic [15:0] idx;
  logic take;
  logic trunc_now;
  logic end_now;
  logic len_bad;
  logic pay_bad;
  logic em;
  logic [7:0] eb;
  logic [31:0] word_n;
  logic push;
  logic full;
  logic wr;
  logic [AW:0] wptr_n;
  mrx_pkg::mrx_word_s push_w;

  always_comb begin
    is_vlan = (cnt_reg > mrx_pkg::HDR_BASIC - 16'h0001) && (lt_reg == mrx_pkg::TPID_VLAN);
    is_stack = is_vlan && (cnt_reg > mrx_pkg::HDR_VLAN - 16'h0001) && (in16_reg == mrx_pkg::TPID_VLAN);
    if (is_stack) begin
      clt = in20_reg;
      hdr = mrx_pkg::HDR_STACK;
      minp = mrx_pkg::PAY_MIN_STACK;
      maxl = 16'(cfg_reg.max_len + mrx_pkg::STACK_EXTRA);
    end else if (is_vlan) begin
      clt = in16_reg;
      hdr = mrx_pkg::HDR_VLAN;
      minp = mrx_pkg::PAY_MIN_VLAN;
      maxl = 16'(cfg_reg.max_len + mrx_pkg::VLAN_EXTRA);
    end else begin
      clt = lt_reg;
      hdr = mrx_pkg::HDR_BASIC;
      minp = mrx_pkg::PAY_MIN_BASIC;
      maxl = cfg_reg.max_len;
    end
    take = (lst_reg == L_RECV) && dv_reg;
    trunc_now = take && (cnt_reg >= 16'(maxl + mrx_pkg::TRUNC_SLACK));
    end_now = ((lst_reg == L_RECV) && !dv_reg) || trunc_now;
    pay = 16'(cnt_reg - hdr - mrx_pkg::CRC_LEN);
    len_bad = (cnt_reg < mrx_pkg::MIN_FRAME_LEN) || (cnt_reg > maxl);
    // Pad shorter than the minimum counts as exactly the minimum
    pay_bad = !cfg_reg.skip_payload_len_check && (clt < mrx_pkg::TYPE_MIN)
              && ((pay < minp) || (pay >= mrx_pkg::PAY_LIMIT)
              || !((clt == pay) || ((clt < minp) && (pay == minp))));
    // Byte emission; with stripping the last four bytes never leave the delay
    em = 1'b0;
    eb = rxd_reg;
    idx = cnt_reg;
    if (take && !trunc_now) begin
      if (cfg_reg.strip_crc_pad) begin
        em = (dly_n_reg == mrx_pkg::DELAY_FULL);
        eb = dly_reg[31:24];
        idx = 16'(cnt_reg - mrx_pkg::CRC_LEN);
        if ((clt < minp) && (idx >= 16'(hdr + clt))) begin
          em = 1'b0;
        end
      end else begin
        em = 1'b1;
      end
    end
    word_n = part_reg;
    word_n[8*(3-int'(lane_reg)) +: 8] = eb;
    push = 1'b0;
    push_w = '0;
    if (em && pend_v_reg) begin
      push = 1'b1;
      push_w.data = pend_reg;
      push_w.sop = sop_pend_reg;
    end else if (end_now) begin
      push = 1'b1;
      push_w.sop = sop_pend_reg;
      push_w.eop = 1'b1;
      if (part_v_reg) begin
        push_w.data = part_reg;
        push_w.empty = 2'(3'h4 - {1'b0, lane_reg});
      end else begin
        push_w.data = pend_reg;
      end
      push_w.err[LEN_BIT] = len_bad || pay_bad;
      push_w.err[mrx_pkg::ERR_PHY] = phy_err_reg;
      push_w.err[mrx_pkg::ERR_TRUNC] = trunc_now || ovf_reg;
    end
    full = (wgray_reg == {~rgray_s2_reg[AW:AW-1], rgray_s2_reg[AW-2:0]});
    wr = push && !full;
    wptr_n = (AW+1)'(wptr_reg + 1'b1);
  end

  // ==========================================================================
  // Link receive sequencing
  always_ff @(posedge gmii_rx_clk or posedge lrst_reg) begin
    if (lrst_reg) begin
      lst_reg <= L_IDLE;
      cnt_reg <= mrx_pkg::CNT_RESET;
      lt_reg <= mrx_pkg::CNT_RESET;
      in16_reg <= mrx_pkg::CNT_RESET;
      in20_reg <= mrx_pkg::CNT_RESET;
      dly_reg <= mrx_pkg::WORD_RESET;
      dly_n_reg <= 3'h0;
      phy_err_reg <= 1'b0;
    end else begin
      case (lst_reg)
        L_IDLE: begin
          if (dv_reg && (rxd_reg == mrx_pkg::SFD_BYTE)) begin
            lst_reg <= L_RECV;
            cnt_reg <= mrx_pkg::CNT_RESET;
            lt_reg <= mrx_pkg::CNT_RESET;
            in16_reg <= mrx_pkg::CNT_RESET;
            in20_reg <= mrx_pkg::CNT_RESET;
            dly_n_reg <= 3'h0;
            phy_err_reg <= 1'b0;
          end else if (dv_reg && (rxd_reg != mrx_pkg::PREAMBLE_BYTE)) begin
            lst_reg <= L_DROP;
          end
        end
        L_RECV: begin
          if (end_now) begin
            lst_reg <= trunc_now ? L_DROP : L_IDLE;
          end else if (take) begin
            cnt_reg <= 16'(cnt_reg + 16'h0001);
            phy_err_reg <= phy_err_reg | er_reg;
            dly_reg <= {dly_reg[23:0], rxd_reg};
            if (dly_n_reg != mrx_pkg::DELAY_FULL) begin
              dly_n_reg <= 3'(dly_n_reg + 3'h1);
            end
            if (cnt_reg == mrx_pkg::LT_POS) begin
              lt_reg[15:8] <= rxd_reg;
            end
            if (cnt_reg == 16'(mrx_pkg::LT_POS + 16'h0001)) begin
              lt_reg[7:0] <= rxd_reg;
            end
            if (cnt_reg == mrx_pkg::INNER_POS) begin
              in16_reg[15:8] <= rxd_reg;
            end
            if (cnt_reg == 16'(mrx_pkg::INNER_POS + 16'h0001)) begin
              in16_reg[7:0] <= rxd_reg;
            end
            if (cnt_reg == mrx_pkg::CLT_STACK_POS) begin
              in20_reg[15:8] <= rxd_reg;
            end
            if (cnt_reg == 16'(mrx_pkg::CLT_STACK_POS + 16'h0001)) begin
              in20_reg[7:0] <= rxd_reg;
            end
          end
        end
        L_DROP: begin
          if (!dv_reg) begin
            lst_reg <= L_IDLE;
          end
        end
        default: begin
          lst_reg <= L_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Word packer
  always_ff @(posedge gmii_rx_clk or posedge lrst_reg) begin
    if (lrst_reg) begin
      part_reg <= mrx_pkg::WORD_RESET;
      lane_reg <= mrx_pkg::PLAIN_START_LANE;
      part_v_reg <= 1'b0;
      pend_reg <= mrx_pkg::WORD_RESET;
      pend_v_reg <= 1'b0;
      sop_pend_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      if ((lst_reg == L_IDLE) && dv_reg && (rxd_reg == mrx_pkg::SFD_BYTE)) begin
        // Alignment leaves the two upper lanes of the first word at zero
        lane_reg <= cfg_reg.rx_align_en ? mrx_pkg::ALIGN_START_LANE : mrx_pkg::PLAIN_START_LANE;
        part_reg <= mrx_pkg::WORD_RESET;
        part_v_reg <= 1'b0;
        pend_v_reg <= 1'b0;
        sop_pend_reg <= 1'b1;
      end else if (em) begin
        if (lane_reg == 2'h3) begin
          pend_reg <= word_n;
          pend_v_reg <= 1'b1;
          part_reg <= mrx_pkg::WORD_RESET;
          part_v_reg <= 1'b0;
          lane_reg <= 2'h0;
        end else begin
          part_reg <= word_n;
          part_v_reg <= 1'b1;
          lane_reg <= 2'(lane_reg + 2'h1);
          pend_v_reg <= 1'b0;
        end
      end else if (end_now) begin
        part_v_reg <= 1'b0;
        pend_v_reg <= 1'b0;
      end
      if (push) begin
        sop_pend_reg <= 1'b0;
      end
      if (push && full) begin
        ovf_reg <= 1'b1;
      end else if (wr && end_now) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Word crossing into the client domain, gray-coded pointers
  always_ff @(posedge gmii_rx_clk) begin
    if (wr) begin
      mem[wptr_reg[AW-1:0]] <= push_w;
    end
  end

  always_ff @(posedge gmii_rx_clk or posedge lrst_reg) begin
    if (lrst_reg) begin
      wptr_reg <= '0;
      wgray_reg <= '0;
      rgray_s1_reg <= '0;
      rgray_s2_reg <= '0;
    end else begin
      if (wr) begin
        wptr_reg <= wptr_n;
        wgray_reg <= wptr_n ^ (wptr_n >> 1);
      end
      rgray_s1_reg <= rgray_reg;
      rgray_s2_reg <= rgray_s1_reg;
    end
  end

  // ==========================================================================
  // Client domain delivery
  logic [AW:0] wgray_s1_reg;
  logic [AW:0] wgray_s2_reg;
  logic [AW:0] rptr_reg;
  mrx_sstate_e sst_reg;
  logic in_frame_reg;
  logic owe_err_reg;
  logic empty;
  logic emit_owed;
  logic pop;
  logic [AW:0] rptr_n;
  logic [AW:0] level;
  mrx_pkg::mrx_word_s head;

  always_comb begin
    empty = (rgray_reg == wgray_s2_reg);
    head = mem[rptr_reg[AW-1:0]];
    emit_owed = (sst_reg == S_PASS) && owe_err_reg && rx_ready;
    pop = !emit_owed && !empty;
    rptr_n = (AW+1)'(rptr_reg + 1'b1);
    level = (AW+1)'(gray_to_bin(wgray_s2_reg) - rptr_reg);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wgray_s1_reg <= '0;
      wgray_s2_reg <= '0;
      rptr_reg <= '0;
      rgray_reg <= '0;
    end else begin
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
      if (pop) begin
        rptr_reg <= rptr_n;
        rgray_reg <= rptr_n ^ (rptr_n >> 1);
      end
    end
  end

  // No back-pressure: a word that meets a busy client is lost with its frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sst_reg <= S_PASS;
      in_frame_reg <= 1'b0;
      owe_err_reg <= 1'b0;
      rx_valid <= 1'b0;
      rx_beat <= '0;
    end else begin
      rx_valid <= 1'b0;
      case (sst_reg)
        S_PASS: begin
          if (emit_owed) begin
            rx_valid <= 1'b1;
            rx_beat <= '0;
            rx_beat.eop <= 1'b1;
            rx_beat.err[LEN_BIT] <= 1'b1;
            rx_beat.err[mrx_pkg::ERR_TRUNC] <= 1'b1;
            owe_err_reg <= 1'b0;
          end else if (pop) begin
            if (rx_ready) begin
              rx_valid <= 1'b1;
              rx_beat <= head;
              in_frame_reg <= !head.eop && (head.sop || in_frame_reg);
            end else begin
              owe_err_reg <= owe_err_reg || in_frame_reg;
              in_frame_reg <= 1'b0;
              if (!head.eop) begin
                sst_reg <= S_DROP;
              end
            end
          end
        end
        S_DROP: begin
          if (pop && head.eop) begin
            sst_reg <= S_PASS;
          end
        end
        default: begin
          sst_reg <= S_PASS;
        end
      endcase
    end
  end

  // ==========================================================================
  // Level thresholds, counted in 32-bit words
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_a_empty <= 1'b1;
      rx_a_full <= 1'b0;
      rx_sect_empty <= 1'b0;
      rx_sect_full <= 1'b0;
    end else begin
      rx_a_empty <= mrx_pkg::THR_W'(level) <= thr.almost_empty;
      rx_a_full <= mrx_pkg::THR_W'(DEPTH - int'(level)) <= thr.almost_full;
      rx_sect_empty <= mrx_pkg::THR_W'(level) >= thr.section_empty;
      rx_sect_full <= mrx_pkg::THR_W'(level) >= thr.section_full;
    end
  end

endmodule

// ==== sim/mrx_phy_model.sv ====
// PHY receive model driving the byte-wide receive pins.
// Assumes the bench runs gmii_rx_clk continuously.
`timescale 1ns/1ps
module mrx_phy_model (
  input wire logic gmii_rx_clk, // Link clock
  output logic gmii_rx_dv, // Data valid
  output logic gmii_rx_er, // Symbol error
  output logic [7:0] gmii_rxd // Data byte
);
  initial begin
    gmii_rx_dv = 1'b0;
    gmii_rx_er = 1'b0;
    gmii_rxd = 8'h00;
  end

  // ==========
  // Preamble, delimiter, frame; idle data is the inverse of the last byte
  task automatic send(input logic [7:0] fr[$], input logic er_on);
    for (int i = -8; i < fr.size(); i++) begin
      @(posedge gmii_rx_clk);
      #1;
      gmii_rx_dv = 1'b1;
      gmii_rxd = (i < -1) ? mrx_pkg::PREAMBLE_BYTE : (i == -1) ? mrx_pkg::SFD_BYTE : fr[i];
      gmii_rx_er = er_on && (i == 20);
    end
    @(posedge gmii_rx_clk);
    #1;
    gmii_rx_dv = 1'b0;
    gmii_rx_er = 1'b0;
    gmii_rxd = ~gmii_rxd;
    repeat (3) @(posedge gmii_rx_clk);
  endtask
endmodule

// ==== sim/mrx_rx_frame_writer_properties.sv ====
// Port checker for the receive frame writer.
// Assumes it is bound onto every mrx_rx_frame_writer instance.
`timescale 1ns/1ps
module mrx_rx_frame_writer_chk #(
  parameter bit FIFO_VARIANT = 1'b0
) (
  input wire logic ref_clk, // Client clock
  input wire logic rst, // Reset
  input wire logic gmii_rx_clk, // Link clock
  input wire logic gmii_rx_dv, // Data valid
  input wire logic gmii_rx_er, // Symbol error
  input wire logic [7:0] gmii_rxd, // Data byte
  input wire mrx_pkg::mrx_cfg_s cfg, // Configuration
  input wire mrx_pkg::mrx_thr_s thr, // Thresholds
  input wire logic rx_ready, // Client ready
  input wire mrx_pkg::mrx_word_s rx_beat, // Client beat
  input wire logic rx_valid, // Beat valid
  input wire logic rx_a_empty, // Almost empty
  input wire logic rx_a_full, // Almost full
  input wire logic rx_sect_empty, // Section empty
  input wire logic rx_sect_full // Section full
);
  localparam int LEN_BIT = FIFO_VARIANT ? mrx_pkg::ERR_LEN_FIFO : mrx_pkg::ERR_LEN_STREAM;
  localparam int ALT_BIT = FIFO_VARIANT ? mrx_pkg::ERR_LEN_STREAM : mrx_pkg::ERR_LEN_FIFO;
  logic in_frame_reg;

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ==========
  // Frame tracking
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      in_frame_reg <= 1'b0;
    else if (rx_valid)
      in_frame_reg <= !rx_beat.eop;
  end

  sequence s_head;
    rx_valid && rx_beat.sop;
  endsequence
  sequence s_tail;
    rx_valid && rx_beat.eop;
  endsequence
  sequence s_fresh;
    rx_valid && !in_frame_reg;
  endsequence

  // ==========
  // Properties
  AST_RESET_QUIET: assert property (disable iff (1'b0) rst |-> !rx_valid && rx_a_empty && !rx_a_full)
    else $error("outputs not idle in reset");
  AST_READY_LAT: assert property (rx_valid |-> $past(rx_ready))
    else $error("beat without ready one cycle before");
  AST_FRESH_SOP: assert property (s_fresh |-> rx_beat.sop)
    else $error("frame starts without sop");
  AST_TAIL_NEXT: assert property (s_tail ##1 rx_valid |-> rx_beat.sop)
    else $error("beat after eop lacks sop");
  AST_LEN_EOP: assert property (rx_valid && rx_beat.err[LEN_BIT] |-> rx_beat.eop)
    else $error("length error off the eop beat");
  AST_LEN_BIT: assert property (rx_valid |-> !rx_beat.err[ALT_BIT])
    else $error("length error on wrong bit");
  AST_TRUNC_EOP: assert property (rx_valid && rx_beat.err[mrx_pkg::ERR_TRUNC] |-> rx_beat.eop)
    else $error("truncation flag off the eop beat");
  AST_ALIGN_HEAD: assert property (s_head |-> !cfg.rx_align_en || rx_beat.data[31:16] == 16'h0000)
    else $error("aligned head not zero padded");
  AST_FULL_MID: assert property (rx_valid && !rx_beat.eop |-> rx_beat.empty == 2'h0)
    else $error("empty lanes before eop");
  AST_THR_ES: assert property ($stable(thr) && thr.section_empty > thr.almost_empty
    |-> !(rx_a_empty && rx_sect_empty))
    else $error("almost empty and section empty clash");
  AST_THR_FS: assert property ($stable(thr) && thr.section_full >= thr.section_empty
    |-> !rx_sect_full || rx_sect_empty)
    else $error("section full without section empty");
  AST_THR_EF: assert property ($stable(thr) && {1'b0, thr.almost_empty} + {1'b0, thr.almost_full} < 9'h004
    |-> !(rx_a_empty && rx_a_full))
    else $error("almost empty and almost full clash");
endmodule

bind mrx_rx_frame_writer mrx_rx_frame_writer_chk #(.FIFO_VARIANT(FIFO_VARIANT)) u_chk (.ref_clk(ref_clk),
  .rst(rst), .gmii_rx_clk(gmii_rx_clk), .gmii_rx_dv(gmii_rx_dv), .gmii_rx_er(gmii_rx_er), .gmii_rxd(gmii_rxd),
  .cfg(cfg), .thr(thr), .rx_ready(rx_ready), .rx_beat(rx_beat), .rx_valid(rx_valid), .rx_a_empty(rx_a_empty),
  .rx_a_full(rx_a_full), .rx_sect_empty(rx_sect_empty), .rx_sect_full(rx_sect_full));

// ==== sim/tb_mrx_rx_frame_writer.sv ====
// Self-checking bench for the receive frame writer.
// Assumes the PHY model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_mrx_rx_frame_writer;
  logic ref_clk = 1'b0;
  logic gmii_rx_clk = 1'b0;
  logic rst = 1'b0;
  logic rx_ready = 1'b1;
  logic dv;
  logic er;
  logic [7:0] rxd;
  logic [3:0] flags;
  logic rx_valid;
  logic loose = 1'b0;
  int bad_count = 0;
  int n_compared = 0;
  int fld;
  mrx_pkg::mrx_cfg_s cfg = {16'h0064, 3'h0};
  mrx_pkg::mrx_thr_s thr = 32'h0000_0000;
  mrx_pkg::mrx_word_s rx_beat;
  mrx_pkg::mrx_word_s mon_w;
  mrx_pkg::mrx_word_s got_q[$];
  mrx_pkg::mrx_word_s exp_q[$];
  logic [7:0] fr[$];

  always #25 ref_clk = ~ref_clk;
  always #40 gmii_rx_clk = ~gmii_rx_clk;

  mrx_rx_frame_writer DUT (.ref_clk(ref_clk), .rst(rst), .gmii_rx_clk(gmii_rx_clk), .gmii_rx_dv(dv),
    .gmii_rx_er(er), .gmii_rxd(rxd), .cfg(cfg), .thr(thr), .rx_ready(rx_ready), .rx_beat(rx_beat),
    .rx_valid(rx_valid), .rx_a_empty(flags[3]), .rx_a_full(flags[2]), .rx_sect_empty(flags[1]),
    .rx_sect_full(flags[0]));
  mrx_phy_model u_phy (.gmii_rx_clk(gmii_rx_clk), .gmii_rx_dv(dv), .gmii_rx_er(er), .gmii_rxd(rxd));

  // ==========
  // Beat capture; unused lanes of the last word are masked
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      mon_w = rx_beat;
      mon_w.data = mon_w.data & ~((32'h1 << {mon_w.empty, 3'h0}) - 32'h1);
      got_q.push_back(mon_w);
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========
  // Frame building and expectation
  task automatic make_frame(input int kind, input int len, input int mode);
    int hdr;
    hdr = 14 + 4 * kind;
    fld = (mode < 2) ? len - hdr - 4 + mode : (mode == 2) ? 16'h0800 : 41 - 4 * kind;
    fr.delete();
    repeat (len) fr.push_back(8'($urandom));
    if (kind > 0) {fr[12], fr[13]} = mrx_pkg::TPID_VLAN;
    if (kind > 1) {fr[16], fr[17]} = mrx_pkg::TPID_VLAN;
    {fr[hdr - 2], fr[hdr - 1]} = 16'(fld);
  endtask

  function automatic void expect_frame(input int kind, input logic er_on);
    int n;
    int hdr;
    int pmin;
    int lim;
    int pay;
    int k;
    logic lerr;
    logic trunc;
    logic [7:0] b[$];
    mrx_pkg::mrx_word_s w;
    n = fr.size();
    hdr = 14 + 4 * kind;
    pmin = 46 - 4 * kind;
    lim = int'(cfg.max_len) + 4 * kind;
    pay = n - hdr - 4;
    trunc = n > lim + 11;
    lerr = n < mrx_pkg::MIN_FRAME_LEN || n > lim;
    if (!lerr && !cfg.skip_payload_len_check && fld < mrx_pkg::TYPE_MIN)
      lerr = pay < pmin || pay >= mrx_pkg::PAY_LIMIT || !(pay == fld || (fld < pmin && pay == pmin));
    k = trunc ? lim + 11 : !cfg.strip_crc_pad ? n : fld < pmin ? hdr + fld : n - 4;
    if (cfg.rx_align_en) b = '{8'h00, 8'h00};
    for (int i = 0; i < k; i++) b.push_back(fr[i]);
    for (int i = 0; i < b.size(); i += 4) begin
      w = '0;
      for (int j = 0; j < 4; j++) if (i + j < b.size()) w.data[31 - 8 * j -: 8] = b[i + j];
      w.sop = (i == 0);
      w.eop = (i + 4 >= b.size());
      w.empty = w.eop ? 2'(i + 4 - b.size()) : 2'h0;
      w.err = w.eop ? {trunc, er_on, 1'b0, lerr} : 4'h0;
      exp_q.push_back(w);
    end
  endfunction

  task automatic run_frame(input int kind, input int len, input int mode, input logic er_on);
    make_frame(kind, len, mode);
    exp_q.delete();
    got_q.delete();
    expect_frame(kind, er_on);
    u_phy.send(fr, er_on);
    repeat (20) @(posedge ref_clk);
    #1;
    if (loose)
      check({got_q[$].eop, got_q[$].err}, 5'h19);
    else
      check(got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (!loose && i < got_q.size()) check(got_q[i], exp_q[i]);
  endtask

  // ==========
  // Main sequence
  initial begin
    int n;
    void'($urandom(32'haf8e));
    // Rising edge after time zero so every asynchronous reset sees it
    #1;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 6; i++) begin
      thr = {8'($urandom % 6), 8'($urandom % 6), 8'($urandom % 2), 8'($urandom % 2)};
      repeat (3) @(posedge ref_clk);
      #1;
      check(flags, {1'b1, thr.almost_full >= 8'h04, thr.section_empty == 8'h00, thr.section_full == 8'h00});
    end
    for (int k = 0; k < 3; k++) begin
      run_frame(k, 63, 0, 1'b0);
      run_frame(k, 64, 0, 1'b0);
      run_frame(k, 100 + 4 * k, 0, 1'b0);
      run_frame(k, 101 + 4 * k, 0, 1'b0);
      run_frame(k, 64, 1, 1'b0);
      run_frame(k, 70, 2, 1'b0);
      cfg.strip_crc_pad = 1'b1;
      run_frame(k, 64, 3, 1'b0);
      cfg.strip_crc_pad = 1'b0;
      loose = 1'b1;
      run_frame(k, 117 + 4 * k, 0, 1'b0);
      loose = 1'b0;
    end
    for (int i = 0; i < 15; i++) begin
      cfg = {16'h0064, 3'($urandom)};
      run_frame($urandom % 3, 60 + $urandom % 52, $urandom % 3, ($urandom % 4) == 0);
    end
    // Client stalls mid-frame, then a whole frame passes while it stalls
    cfg = {16'h0064, 3'h0};
    make_frame(0, 80, 0);
    got_q.delete();
    fork
      u_phy.send(fr, 1'b0);
      begin
        repeat (60) @(posedge ref_clk);
        #1;
        rx_ready = 1'b0;
      end
    join
    u_phy.send(fr, 1'b0);
    repeat (20) @(posedge ref_clk);
    #1;
    rx_ready = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1;
    check({got_q[$].eop, got_q[$].err, got_q[$].data}, {1'b1, 4'h9, 32'h0000_0000});
    n = 0;
    foreach (got_q[i]) n += got_q[i].sop;
    check(n, 1);
    final_report();
  end

  // Limit is several times the expected run length
  initial begin
    #3_000_000;
    bad_count++;
    final_report();
  end
endmodule
